//--- hdl/apsm_scrambler.sv
// side-stream additive scrambler, one or two sequence bits per step
`timescale 1ns/10ps
`include "apsm_regs.svh"
module apsm_scrambler #(
    parameter int                 WIDTH = `APSM_SCR_WIDTH,
    parameter logic [WIDTH-1:0]   TAPS  = `APSM_LS_SCR_TAPS,
    parameter logic [WIDTH-1:0]   SEED  = `APSM_SCR_SEED
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             enable,
    // stepping
    input  wire logic             advance,
    input  wire logic             double_step,
    // sequence bits, bit 0 is the additive bit
    output logic [1:0]            seq_bits
);
    logic [WIDTH-1:0] state;

    // refused at elaboration: a short or all-zero register never moves
    if (WIDTH < 3 || SEED == '0) begin : g_bad_cfg
        $error("scrambler needs width of 3 or more and a nonzero seed");
    end

    function automatic logic [WIDTH-1:0] step(input logic [WIDTH-1:0] s);
        step = {s[WIDTH-2:0], ^(s & TAPS)};
    endfunction

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= SEED;
        end else if (enable && advance) begin
            state <= double_step ? step(step(state)) : step(state);
        end
    end

    assign seq_bits = state[1:0];
endmodule

//--- hdl/apsm_symbol_mapper.sv
// pcs symbol path: low-rate symbol source, high-rate scramble and map, rx tag
//
// Operation
// - data mode sends gapless DME symbol stream
// - training mode sends only training symbols
// - zeros request in training sends zero symbols
// - quiet LPI in data mode sends zeros
// - one receive indication per detected symbol
// - 10G maps symbol values to PAM4 levels
// - 2.5G/5G maps bits to PAM2 levels
// - 2.5G/5G scrambles every superframe bit
// - additive bit xor data bit forms output
// - first polynomial low rate, second high
// - receiver reads PAM2 at 2.5G/5G
// - behaviour independent of optional client interface
// - symbol period from rate factor formula
// - normal mode emits coded symbols every period outside quiet LPI
// - low-rate frame spans 300 symbol transfers
`timescale 1ns/10ps
`include "apsm_regs.svh"
module apsm_symbol_mapper #(
    parameter int           RATE_FACTOR = `APSM_RATE_FACTOR,
    parameter int           FRAME_SYMBOLS = `APSM_FRAME_SYMBOLS,
    parameter logic [1:0]   TRAIN_SYMB  = `APSM_TRAIN_SYMB_DEFAULT
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire logic                     enable,
    // configuration and phy control
    input  wire apsm_pkg::apsm_rate_t     rate_cfg,
    input  wire apsm_pkg::apsm_tx_mode_t  tx_mode,
    input  wire logic                     lpi_quiet,
    // low-rate coded frame bits
    input  wire logic                     ls_bit,
    output logic                          ls_bit_taken,
    output logic                          ls_frame_start,
    // low-rate symbols to the attachment sublayer
    output apsm_pkg::apsm_ls_tx_t         ls_tx,
    // high-rate coded bits in, levels out
    input  wire apsm_pkg::apsm_hs_in_t    hs_in,
    output apsm_pkg::apsm_hs_out_t        hs_out,
    // receive side pins from the attachment sublayer
    input  wire logic                     rx_strobe_pin,
    input  wire logic [2:0]               rx_level_pin,
    output apsm_pkg::apsm_rx_ind_t        rx_ind
);
    // symbol period in fs, then whole clock cycles, never under one
    localparam longint SYM_PERIOD_FS = (longint'(`APSM_SYM_PERIOD_NUM_PS)
        * 64'd1000000) / (longint'(`APSM_SYM_RATE_MILLI) * RATE_FACTOR);
    localparam longint SYM_CYC_RAW = SYM_PERIOD_FS
        / (longint'(`APSM_CLK_PERIOD_PS) * 64'd1000);
    localparam int SYM_CYCLES = (SYM_CYC_RAW < 1) ? 1 : int'(SYM_CYC_RAW);
    localparam int DIV_W = (SYM_CYCLES > 1) ? $clog2(SYM_CYCLES) : 1;
    localparam int FRM_W = $clog2(FRAME_SYMBOLS);

    if (RATE_FACTOR < 1 || FRAME_SYMBOLS < 2) begin : g_bad_cfg
        $error("rate factor or frame length out of range");
    end

    function automatic apsm_pkg::apsm_level_t pam4_level(
        input logic [1:0] v);
        case (v)
            2'h0:    pam4_level = `APSM_LVL_M1;
            2'h1:    pam4_level = `APSM_LVL_M1_3;
            2'h2:    pam4_level = `APSM_LVL_P1_3;
            default: pam4_level = `APSM_LVL_P1;
        endcase
    endfunction

    function automatic logic is_pam2(input apsm_pkg::apsm_rate_t r);
        is_pam2 = (r != apsm_pkg::APSM_RATE_10G);
    endfunction

    // ---------------- low-rate symbol timing ----------------
    logic [DIV_W-1:0] div_cnt;
    logic             sym_tick;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
        end else if (enable) begin
            if (div_cnt == DIV_W'(SYM_CYCLES - 1)) begin
                div_cnt <= '0;
            end else begin
                div_cnt <= div_cnt + DIV_W'(1);
            end
        end
    end
    assign sym_tick = enable && (div_cnt == DIV_W'(SYM_CYCLES - 1));

    // ---------------- symbol source selection ----------------
    apsm_pkg::apsm_src_t src;
    apsm_pkg::apsm_src_t next_src;

    always_comb begin
        case (tx_mode)
            apsm_pkg::APSM_MODE_NORMAL: next_src = apsm_pkg::APSM_SRC_DATA;
            apsm_pkg::APSM_MODE_ZEROS:  next_src = apsm_pkg::APSM_SRC_ZERO;
            apsm_pkg::APSM_MODE_TRAIN:  next_src = apsm_pkg::APSM_SRC_TRAIN;
            default:                    next_src = apsm_pkg::APSM_SRC_ZERO;
        endcase
    end

    // source changes only at a symbol boundary so no symbol is split
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src <= apsm_pkg::APSM_SRC_RESET;
        end else if (sym_tick) begin
            src <= next_src;
        end
    end

    // ---------------- low-rate scrambler and DME ----------------
    logic       ls_take;
    logic [1:0] ls_seq;
    logic       ls_scr_bit;
    logic       dme_level;
    logic [1:0] next_dme;

    // quiet LPI only applies once data mode is the live source
    assign ls_take = sym_tick && (src == apsm_pkg::APSM_SRC_DATA)
                     && !lpi_quiet;

    apsm_scrambler #(
        .WIDTH (`APSM_SCR_WIDTH),
        .TAPS  (`APSM_LS_SCR_TAPS),
        .SEED  (`APSM_SCR_SEED)
    ) u_ls_scr (
        .clock       (clock),
        .rst_n       (rst_n),
        .enable      (enable),
        .advance     (ls_take),
        .double_step (1'b0),
        .seq_bits    (ls_seq)
    );

    assign ls_scr_bit = ls_bit ^ ls_seq[0];
    // dme: level flips at every boundary, and again mid-bit for a one
    assign next_dme = {~dme_level, ls_scr_bit ? dme_level : ~dme_level};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dme_level <= 1'b0;
        end else if (ls_take) begin
            dme_level <= next_dme[0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ls_tx <= '{valid: 1'b0, symb: `APSM_TX_SYMB_RESET};
        end else if (enable) begin
            ls_tx.valid <= sym_tick && (src != apsm_pkg::APSM_SRC_RESET);
            if (sym_tick) begin
                case (src)
                    apsm_pkg::APSM_SRC_DATA: begin
                        ls_tx.symb <= lpi_quiet ? `APSM_TX_SYMB_ZERO
                                                : next_dme;
                    end
                    apsm_pkg::APSM_SRC_ZERO: begin
                        ls_tx.symb <= `APSM_TX_SYMB_ZERO;
                    end
                    apsm_pkg::APSM_SRC_TRAIN: begin
                        ls_tx.symb <= TRAIN_SYMB;
                    end
                    default: begin
                        ls_tx.symb <= `APSM_TX_SYMB_RESET;
                    end
                endcase
            end
        end
    end

    // ---------------- frame position ----------------
    logic [FRM_W-1:0] frm_cnt;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frm_cnt        <= '0;
            ls_frame_start <= 1'b0;
            ls_bit_taken   <= 1'b0;
        end else if (enable) begin
            ls_bit_taken   <= ls_take;
            ls_frame_start <= ls_take && (frm_cnt == '0);
            if (ls_take) begin
                if (frm_cnt == FRM_W'(FRAME_SYMBOLS - 1)) begin
                    frm_cnt <= '0;
                end else begin
                    frm_cnt <= frm_cnt + FRM_W'(1);
                end
            end
        end
    end

    // ---------------- high-rate scramble and level map ----------------
    logic       hs_pam2;
    logic [1:0] hs_seq;
    logic [1:0] hs_scr;

    assign hs_pam2 = is_pam2(rate_cfg);

    apsm_scrambler #(
        .WIDTH (`APSM_SCR_WIDTH),
        .TAPS  (`APSM_HS_SCR_TAPS),
        .SEED  (`APSM_SCR_SEED)
    ) u_hs_scr (
        .clock       (clock),
        .rst_n       (rst_n),
        .enable      (enable),
        .advance     (hs_in.valid),
        .double_step (!hs_pam2),
        .seq_bits    (hs_seq)
    );

    // every bit meets its own sequence bit before mapping
    assign hs_scr = hs_in.bits ^ (hs_pam2 ? {1'b0, hs_seq[0]}
                                          : hs_seq);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hs_out <= '{valid: 1'b0, level: `APSM_LEVEL_RESET};
        end else if (enable) begin
            hs_out.valid <= hs_in.valid;
            if (hs_in.valid) begin
                if (hs_pam2) begin
                    hs_out.level <= hs_scr[0] ? `APSM_LVL_P1
                                              : `APSM_LVL_M1;
                end else begin
                    hs_out.level <= pam4_level(hs_scr);
                end
            end
        end
    end

    // ---------------- receive symbol tagging ----------------
    // strobe toggles once per symbol on the recovered clock; the level
    // must stay put for three clocks around each toggle to cross intact
    logic [1:0] rx_sync_tgl;
    logic [2:0] rx_sync_lvl1;
    logic [2:0] rx_sync_lvl2;
    logic       rx_tgl_seen;
    logic       rx_event;
    logic [1:0] rx_bits;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync_tgl  <= 2'h0;
            rx_sync_lvl1 <= 3'h0;
            rx_sync_lvl2 <= 3'h0;
            rx_tgl_seen  <= 1'b0;
        end else if (enable) begin
            rx_sync_tgl  <= {rx_sync_tgl[0], rx_strobe_pin};
            rx_sync_lvl1 <= rx_level_pin;
            rx_sync_lvl2 <= rx_sync_lvl1;
            rx_tgl_seen  <= rx_sync_tgl[1];
        end
    end

    assign rx_event = enable && (rx_sync_tgl[1] != rx_tgl_seen);

    // sign slicer for two levels, inverse of the transmit table for four
    always_comb begin
        if (is_pam2(rate_cfg)) begin
            rx_bits = {1'b0, !rx_sync_lvl2[2]};
        end else begin
            rx_bits = {!rx_sync_lvl2[2], rx_sync_lvl2[1]};
        end
    end

    // one indication per symbol; no client-interface option alters it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_ind <= '{valid: 1'b0, pam2: 1'b1, bits: `APSM_RX_BITS_RESET};
        end else if (enable) begin
            rx_ind.valid <= rx_event;
            if (rx_event) begin
                rx_ind.pam2 <= is_pam2(rate_cfg);
                rx_ind.bits <= rx_bits;
            end
        end
    end

    // ---------------- checks ----------------
    sequence s_data_tick;
        sym_tick && src == apsm_pkg::APSM_SRC_DATA && !lpi_quiet;
    endsequence

    sequence s_symbol_out;
        ##1 ls_tx.valid;
    endsequence

    chk_ls_no_gap: assert property (@(posedge clock) disable iff (!rst_n)
        s_data_tick |-> s_symbol_out and ##1 ls_bit_taken)
        else $error("data symbol missing in its period");

    chk_train_only: assert property (@(posedge clock) disable iff (!rst_n)
        sym_tick && src == apsm_pkg::APSM_SRC_TRAIN
        |=> ls_tx.valid && ls_tx.symb == TRAIN_SYMB)
        else $error("non-training symbol in training");

    chk_zero_train: assert property (@(posedge clock) disable iff (!rst_n)
        sym_tick && src == apsm_pkg::APSM_SRC_ZERO
        |=> ls_tx.symb == `APSM_TX_SYMB_ZERO && !ls_bit_taken)
        else $error("zeros request sent nonzero symbol");

    chk_zero_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        sym_tick && src == apsm_pkg::APSM_SRC_DATA && lpi_quiet
        |=> ls_tx.symb == `APSM_TX_SYMB_ZERO && !ls_bit_taken)
        else $error("quiet idle sent nonzero symbol");

    chk_rx_one_ind: assert property (@(posedge clock) disable iff (!rst_n)
        enable && $changed(rx_sync_tgl[1]) |-> ##1 rx_ind.valid
        ##1 (!rx_ind.valid || $past(rx_event)))
        else $error("receive indication count wrong");

    chk_pam4_map: assert property (@(posedge clock) disable iff (!rst_n)
        enable && hs_in.valid && !hs_pam2
        |=> hs_out.level == pam4_level($past(hs_scr)))
        else $error("pam4 level mapping wrong");

    chk_pam2_scr: assert property (@(posedge clock) disable iff (!rst_n)
        enable && hs_in.valid && hs_pam2
        |=> (hs_out.level == `APSM_LVL_P1) ==
            $past(hs_in.bits[0] ^ hs_seq[0]))
        else $error("pam2 scrambled level wrong");

    chk_frame_len: assert property (@(posedge clock) disable iff (!rst_n)
        ls_frame_start |-> frm_cnt == FRM_W'(1)
        || $past(frm_cnt) == '0)
        else $error("frame did not restart at zero");

    chk_frame_wrap: assert property (@(posedge clock) disable iff (!rst_n)
        ls_take && frm_cnt == FRM_W'(FRAME_SYMBOLS - 1)
        |=> frm_cnt == '0 ##0 ls_bit_taken)
        else $error("frame not closed after last symbol");

    chk_rx_pam2: assert property (@(posedge clock) disable iff (!rst_n)
        rx_ind.valid && rx_ind.pam2 |-> rx_ind.bits[1] == 1'b0)
        else $error("pam2 receive produced two bits");
endmodule

//--- include/apsm_pkg.sv
// types of the asymmetric phy symbol mapper
package apsm_pkg;

    // transmit mode indication from phy control
    typedef enum logic [1:0] {
        APSM_MODE_NORMAL = 2'h0,
        APSM_MODE_ZEROS  = 2'h1,
        APSM_MODE_TRAIN  = 2'h2
    } apsm_tx_mode_t;

    // line rate configuration
    typedef enum logic [1:0] {
        APSM_RATE_2G5 = 2'h0,
        APSM_RATE_5G  = 2'h1,
        APSM_RATE_10G = 2'h2
    } apsm_rate_t;

    // low-rate symbol source, one-hot
    typedef enum logic [3:0] {
        APSM_SRC_RESET = 4'h1,
        APSM_SRC_DATA  = 4'h2,
        APSM_SRC_ZERO  = 4'h4,
        APSM_SRC_TRAIN = 4'h8
    } apsm_src_t;

    // signed level in units of 1/3
    typedef logic signed [2:0] apsm_level_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] symb;
    } apsm_ls_tx_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] bits;
    } apsm_hs_in_t;

    typedef struct packed {
        logic        valid;
        apsm_level_t level;
    } apsm_hs_out_t;

    typedef struct packed {
        logic       valid;
        logic       pam2;
        logic [1:0] bits;
    } apsm_rx_ind_t;

endpackage

//--- include/apsm_regs.svh
// constants of the asymmetric phy symbol mapper: counts, resets, timing
`ifndef APSM_REGS_SVH
`define APSM_REGS_SVH

// low-rate error-correction frame length in symbol transfers
`define APSM_FRAME_SYMBOLS      300
// symbol period is 1000 / (11.250 * S_up) ps, figures kept as printed
`define APSM_SYM_PERIOD_NUM_PS  1000
`define APSM_SYM_RATE_MILLI     11250
// nominal receive indication rate, per unit of rate factor
`define APSM_RX_NOM_RATE_MHZ    11250
// system clock period
`define APSM_CLK_PERIOD_PS      10000
// uplink rate factor
`define APSM_RATE_FACTOR        1

// side-stream scrambler shape and reset seed
`define APSM_SCR_WIDTH          33
`define APSM_SCR_SEED           33'h1FFFFFFFF
`define APSM_LS_SCR_TAPS        33'h100002000
`define APSM_HS_SCR_TAPS        33'h100000400

// symbol and level reset values, zero and training symbol values
`define APSM_TX_SYMB_RESET      2'h0
`define APSM_TX_SYMB_ZERO       2'h0
`define APSM_TRAIN_SYMB_DEFAULT 2'h1
`define APSM_LEVEL_RESET        3'h0
`define APSM_RX_BITS_RESET      2'h0

// pam levels in units of 1/3
`define APSM_LVL_M1             3'h5
`define APSM_LVL_M1_3           3'h7
`define APSM_LVL_P1_3           3'h1
`define APSM_LVL_P1             3'h3

`endif

//--- sim/apsm_pma_model.sv
// far-side model of the attachment sublayer receive pins
`timescale 1ns/10ps
module apsm_pma_model (
    // clock
    input  wire logic       clock,
    // symbol request from the bench
    input  wire logic       send_req,
    input  wire logic [2:0] send_level,
    // receive pins toward the mapper
    output logic            rx_strobe_pin,
    output logic [2:0]      rx_level_pin
);
    logic [2:0] hold;

    initial begin
        rx_strobe_pin = 1'b0;
        rx_level_pin  = 3'h0;
        hold          = 3'h0;
    end

    // one strobe toggle per symbol, level kept past the 3-cycle sync path
    always @(negedge clock) begin
        if (send_req && hold == 3'h0) begin
            rx_level_pin  <= send_level;
            rx_strobe_pin <= ~rx_strobe_pin;
            hold          <= 3'h5;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
            // hold time over: show a changed level, never the stale one
            if (hold == 3'h1)
                rx_level_pin <= ~rx_level_pin;
        end
    end
endmodule

//--- sim/test_asym_phy_pcs_symbol_mapper.sv
// self-checking bench of the pcs symbol mapper
`timescale 1ns/10ps
`include "apsm_regs.svh"
module test_asym_phy_pcs_symbol_mapper;
    logic                    clock = 1'b0;
    logic                    rst_n = 1'b0;
    logic                    enable = 1'b1;
    apsm_pkg::apsm_rate_t    rate_cfg = apsm_pkg::APSM_RATE_2G5;
    apsm_pkg::apsm_tx_mode_t tx_mode = apsm_pkg::APSM_MODE_NORMAL;
    logic                    lpi_quiet = 1'b0;
    logic                    ls_bit = 1'b0;
    logic                    ls_bit_taken;
    logic                    ls_frame_start;
    apsm_pkg::apsm_ls_tx_t   ls_tx;
    apsm_pkg::apsm_hs_in_t   hs_in = '0;
    apsm_pkg::apsm_hs_out_t  hs_out;
    logic                    rx_strobe_pin;
    logic [2:0]              rx_level_pin;
    apsm_pkg::apsm_rx_ind_t  rx_ind;
    logic                    send_req = 1'b0;
    logic [2:0]              send_level = 3'h0;
    logic [7:0]              cyc = 8'h0;
    logic [2:0]              lv [0:11];
    int                      bad_count = 0;
    int                      checked = 0;

    always #5 clock = ~clock;

    // upstream bit stream, a new bit every cycle
    always @(negedge clock) begin
        cyc    <= cyc + 8'h1;
        ls_bit <= cyc[0] ^ cyc[3];
    end

    apsm_symbol_mapper apsm_symbol_mapper_i (
        .clock(clock), .rst_n(rst_n), .enable(enable),
        .rate_cfg(rate_cfg), .tx_mode(tx_mode), .lpi_quiet(lpi_quiet),
        .ls_bit(ls_bit), .ls_bit_taken(ls_bit_taken),
        .ls_frame_start(ls_frame_start), .ls_tx(ls_tx),
        .hs_in(hs_in), .hs_out(hs_out), .rx_strobe_pin(rx_strobe_pin),
        .rx_level_pin(rx_level_pin), .rx_ind(rx_ind));

    apsm_pma_model apsm_pma_model_i (
        .clock(clock), .send_req(send_req), .send_level(send_level),
        .rx_strobe_pin(rx_strobe_pin), .rx_level_pin(rx_level_pin));

    task check_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    task check_val(input string nm, input logic [3:0] e, input logic [3:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task end_of_test;
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task do_reset(input apsm_pkg::apsm_rate_t r,
                  input apsm_pkg::apsm_tx_mode_t m);
        @(negedge clock);
        rst_n     <= 1'b0;
        rate_cfg  <= r;
        tx_mode   <= m;
        lpi_quiet <= 1'b0;
        hs_in     <= '0;
        #1;
        check_val("rst_hs_out", 4'h0, hs_out);
        check_val("rst_rx_ind", 4'h4, rx_ind);
        check_bit("rst_ls_valid", 1'b0, ls_tx.valid);
        repeat (2) @(negedge clock);
        rst_n <= 1'b1;
    endtask

    // gapless dme stream and frame marks over two frames
    task ls_data;
        int   n;
        logic prev;
        do_reset(apsm_pkg::APSM_RATE_2G5, apsm_pkg::APSM_MODE_NORMAL);
        n    = 0;
        prev = 1'b0;
        while (ls_bit_taken !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        for (int i = 0; i < 600; i++) begin
            check_bit("ls_valid", 1'b1, ls_tx.valid);
            check_bit("ls_taken", 1'b1, ls_bit_taken);
            check_bit("frame_start", i % 300 == 0, ls_frame_start);
            check_bit("dme_edge", ~prev, ls_tx.symb[1]);
            prev = ls_tx.symb[0];
            @(posedge clock);
            #1;
        end
    endtask

    task mode_chk(input apsm_pkg::apsm_tx_mode_t m, input logic q,
                  input logic [1:0] es);
        @(negedge clock);
        tx_mode   <= m;
        lpi_quiet <= q;
        repeat (3) @(posedge clock);
        repeat (4) begin
            #1;
            check_val("ls_symb", {2'h0, es}, {2'h0, ls_tx.symb});
            check_bit("ls_valid", 1'b1, ls_tx.valid);
            check_bit("ls_taken", 1'b0, ls_bit_taken);
            @(posedge clock);
        end
    endtask

    // a low enable must hold ls_bit_taken and ls_tx.valid, then data taking resumes
    task freeze_chk;
        @(negedge clock);
        enable    <= 1'b0;
        lpi_quiet <= 1'b0;
        repeat (3) begin
            @(negedge clock);
            check_bit("frozen_taken", 1'b0, ls_bit_taken);
            check_bit("frozen_valid", 1'b1, ls_tx.valid);
        end
        enable <= 1'b1;
        @(negedge clock);
        check_bit("resumed_taken", 1'b1, ls_bit_taken);
    endtask

    // same scrambler state, inverted data must give mirrored levels
    task hs_run(input apsm_pkg::apsm_rate_t r, input logic [1:0] x);
        int diffs;
        do_reset(r, apsm_pkg::APSM_MODE_TRAIN);
        diffs = 0;
        for (int i = 0; i <= 12; i++) begin
            @(negedge clock);
            // output of input i-1 stands settled at this falling edge
            if (i > 0) begin
                check_bit("hs_valid", 1'b1, hs_out.valid);
                if (x == 2'h0) begin
                    lv[i-1] = hs_out.level;
                    if (hs_out.level !== (i[0] ? 3'h5 : 3'h3))
                        diffs++;
                end else begin
                    check_val("hs_mirror", {1'b0, 3'(~lv[i-1] + 3'h1)},
                              {1'b0, hs_out.level});
                end
                if (r != apsm_pkg::APSM_RATE_10G)
                    check_bit("pam2_lvl", 1'b1, hs_out.level === 3'h3 ||
                              hs_out.level === 3'h5);
            end
            hs_in <= {i < 12, i[1:0] ^ x};
        end
        if (x == 2'h0 && r != apsm_pkg::APSM_RATE_10G)
            check_bit("scrambled", 1'b1, diffs > 0);
    endtask

    task rx_sym(input logic [2:0] lvl, input logic [1:0] eb, input logic ep);
        int n;
        @(negedge clock);
        send_req   <= 1'b1;
        send_level <= lvl;
        @(negedge clock);
        send_req <= 1'b0;
        n = 0;
        while (rx_ind.valid !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        check_val("rx_latency", 4'h3, n[3:0]);
        check_val("rx_bits", {2'h0, eb}, {2'h0, rx_ind.bits});
        check_bit("rx_pam2", ep, rx_ind.pam2);
        @(posedge clock);
        #1;
        check_bit("rx_pulse", 1'b0, rx_ind.valid);
        repeat (4) @(posedge clock);
    endtask

    // cut a hang well past the fewer than 1000 cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (2) @(negedge clock);
        rst_n <= 1'b1;
        ls_data();
        mode_chk(apsm_pkg::APSM_MODE_ZEROS, 1'b0, `APSM_TX_SYMB_ZERO);
        mode_chk(apsm_pkg::APSM_MODE_TRAIN, 1'b0,
                 `APSM_TRAIN_SYMB_DEFAULT);
        mode_chk(apsm_pkg::APSM_MODE_TRAIN, 1'b1,
                 `APSM_TRAIN_SYMB_DEFAULT);
        mode_chk(apsm_pkg::APSM_MODE_NORMAL, 1'b1, `APSM_TX_SYMB_ZERO);
        freeze_chk();
        hs_run(apsm_pkg::APSM_RATE_2G5, 2'h0);
        hs_run(apsm_pkg::APSM_RATE_2G5, 2'h1);
        hs_run(apsm_pkg::APSM_RATE_5G, 2'h0);
        hs_run(apsm_pkg::APSM_RATE_5G, 2'h1);
        hs_run(apsm_pkg::APSM_RATE_10G, 2'h0);
        hs_run(apsm_pkg::APSM_RATE_10G, 2'h3);
        do_reset(apsm_pkg::APSM_RATE_10G, apsm_pkg::APSM_MODE_TRAIN);
        rx_sym(`APSM_LVL_M1, 2'h0, 1'b0);
        rx_sym(`APSM_LVL_M1_3, 2'h1, 1'b0);
        rx_sym(`APSM_LVL_P1_3, 2'h2, 1'b0);
        rx_sym(`APSM_LVL_P1, 2'h3, 1'b0);
        do_reset(apsm_pkg::APSM_RATE_5G, apsm_pkg::APSM_MODE_TRAIN);
        rx_sym(`APSM_LVL_P1, 2'h1, 1'b1);
        rx_sym(`APSM_LVL_M1, 2'h0, 1'b1);
        end_of_test();
    end
endmodule
